// ---- hw/memory_map_pkg.sv ----
package memory_map_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses in data space
  localparam logic [15:0] ADDR_FLASH_CTRL    = 16'h0fd0;
  localparam logic [15:0] ADDR_FLASH_COMMIT  = 16'h0fd1;
  localparam logic [15:0] ADDR_FLASH_MONITOR = 16'h0fd2;
  localparam logic [15:0] ADDR_REMAP_SELECT  = 16'h0fde;
  localparam logic [15:0] ADDR_REMAP_COMMIT  = 16'h0fdf;

  // Commit codes
  localparam logic [7:0] CODE_REMAP      = 8'hd4;
  localparam logic [7:0] CODE_RESET_DIS  = 8'hb2;
  localparam logic [7:0] CODE_FAULT_CLR  = 8'h71;
  localparam logic [7:0] CODE_FLASH      = 8'hd5;

  // Remap select field positions
  localparam int BIT_RESET_DIS = 0;
  localparam int BIT_CODE_RAM  = 1;
  localparam int BIT_VECTOR    = 2;
  // Flash control field position
  localparam int BIT_BOOT_ROM  = 4;

  // Reset values
  localparam logic [2:0] REMAP_RESET = 3'h0;
  localparam logic [7:0] FLASH_RESET = 8'h40;

  // Address windows
  localparam logic [15:0] RAM_LO      = 16'h0040;
  localparam logic [15:0] RAM_HI      = 16'h083f;
  localparam logic [15:0] BOOT_LO     = 16'h1000;
  localparam logic [15:0] BOOT_HI     = 16'h17ff;
  localparam logic [15:0] FLASH_LO    = 16'hc000;
  localparam logic [15:0] FLASH_HI    = 16'hffff;
  localparam logic [15:0] SFR1_LO     = 16'h0000;
  localparam logic [15:0] SFR1_HI     = 16'h003f;
  localparam logic [15:0] SFR2_LO     = 16'h0f00;
  localparam logic [15:0] SFR2_HI     = 16'h0fff;
  localparam logic [15:0] SFR3_LO     = 16'h0e40;
  localparam logic [15:0] SFR3_HI     = 16'h0eff;
  localparam logic [15:0] VCALL_LO    = 16'hffa0;
  localparam logic [15:0] VCALL_HI    = 16'hffbf;
  localparam logic [15:0] VINT_LO     = 16'hffcc;
  localparam logic [15:0] VINT_HI     = 16'hfffd;
  localparam logic [15:0] VCALL_RLO   = 16'h01a0;
  localparam logic [15:0] VINT_RLO    = 16'h01cc;

  // Fixed read values
  localparam logic [7:0] SWI_OPCODE = 8'hff;
  localparam logic [7:0] UNMAPPED   = 8'hff;

  // Memory targets of a decoded access
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RAM,
    TGT_BOOT,
    TGT_FLASH,
    TGT_SFR,
    TGT_SWI
  } target_type;
endpackage

// ---- hw/vector_relocate.sv ----
// Maps a default vector address into its RAM image when relocation is active
module vector_relocate (
  // Fetch address and control
  input  wire logic [15:0] i_addr,
  input  wire logic        i_relocate,
  // Result
  output logic      [15:0] o_addr,
  output logic             o_hit
);
  // Window membership
  wire in_call = (i_addr >= memory_map_pkg::VCALL_LO) && (i_addr <= memory_map_pkg::VCALL_HI);
  // Reset vector at the top word is excluded, it never moves
  wire in_int  = (i_addr >= memory_map_pkg::VINT_LO) && (i_addr <= memory_map_pkg::VINT_HI);
  // Offsets inside each table keep their position
  wire [15:0] call_off = i_addr - memory_map_pkg::VCALL_LO;
  wire [15:0] int_off  = i_addr - memory_map_pkg::VINT_LO;

  assign o_hit  = i_relocate && (in_call || in_int);
  assign o_addr = !o_hit ? i_addr :
                  in_call ? memory_map_pkg::VCALL_RLO + call_off :
                            memory_map_pkg::VINT_RLO + int_off;
endmodule // vector_relocate

// ---- hw/memory_map_remap_control.sv ----
// Function
// - RAM decoded in data space after reset
// - Committed code RAM select maps RAM into code
// - Vector select moves vector tables into RAM
// - Reset vector never relocated
// - Serial PROM mode forces RAM into code
// - Unmapped code RAM fetch returns SOFTWARE_INTERRUPT_OPCODE opcode
// - Code 0xD4 commits RAM and vector selects
// - 0xB2 reset-disable, 0x71 fault-clear, others ignored
// - Commit register write-only, reads give status
// - Status shows committed selects, not pending
// - Upper five bits of select/status read zero
// - Boot ROM unmapped after reset
// - Committed boot select maps ROM both spaces
// - Flash control double-buffered, monitor shows shadow
// - Only first 2 KB boot ROM outside PROM
// - Unmapped boot code fetch: flash or SOFTWARE_INTERRUPT_OPCODE
// - Flash decoded at 0xC000-0xFFFF in code
// - Three SPECIAL_FUNCTION_REGION regions decoded in data space
// - Unmapped boot data reads give 0xFF

// Overview
// The block steers two separate 64 KB spaces, one for instruction fetch
// and one for operand access. It does not hold any memory itself: it only
// names the target of each address and, for fetches, the physical address
// after vector relocation. The memories sit outside and follow the target.
//
// Double buffering
// Software writes land in pending copies first. Nothing steers the decoder
// until a commit code arrives, so a half-written setup can never redirect
// a fetch that is already under way. The price is one extra store per
// change, which software has to remember.
//
// Commit codes
// One commit address serves three separate codes. Each code applies only
// its own pending field, so the reset-disable bit and the remap bits can
// be staged together yet released apart. Any other byte is dropped silently.
//
// Read back
// Reads of the commit address return the committed state, never the byte
// that was stored there. A read-modify-write on that address would thus
// store the status back as a code, which is why software must avoid it.
//
// Timing
// Decode is purely combinational so that a fetch is steered in the cycle
// in which its address appears. Register reads are registered and arrive
// one cycle after the address.
//
// Limitations
// The gear-clock condition for the reset-disable and fault-clear codes is
// not checked here; a code written at another gear setting still applies.
// The serial PROM strap is sampled as a plain level, with no filtering.
module memory_map_remap_control #(
  parameter bit FLASH_COVERS_BOOT = 1'b0  // Large flash reaches down into the boot window for code fetches only
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Mode straps
  input  wire logic        i_serial_prom_mode,
  // Code space fetch
  input  wire logic [15:0] i_code_addr,
  output logic      [2:0]  o_code_target,
  output logic      [15:0] o_code_phys_addr,
  output logic             o_code_force_swi,
  // Data space access
  input  wire logic [15:0] i_data_addr,
  input  wire logic        i_data_rd,
  input  wire logic        i_data_wr,
  input  wire logic [7:0]  i_data_wdata,
  output logic      [2:0]  o_data_target,
  output logic             o_data_force_ff,
  output logic             o_reg_hit,
  output logic      [7:0]  o_reg_rdata,
  // Committed controls to other blocks
  output logic             o_reset_disable,
  output logic             o_fault_clear_pulse,
  output logic      [7:0]  o_flash_control
);
  // Pending remap select bits, written directly by software
  logic [2:0] remap_pending;
  // Committed remap bits; the RAM and vector bits steer the decoder
  logic       code_ram_active_flag;
  logic       vector_relocate_active_flag;
  logic       reset_disable;
  // Flash control written copy and active shadow
  logic [7:0] flash_control;
  logic [7:0] flash_shadow_monitor;
  // One-cycle strobe of the fault-clear commit
  logic       fault_clear_pulse;

  // Register write decode
  // Writes are taken on the edge at which the store is presented; a store
  // held for several cycles would simply be taken again with the same effect.
  wire wr_remap_sel  = i_data_wr && (i_data_addr == memory_map_pkg::ADDR_REMAP_SELECT);
  wire wr_remap_cmt  = i_data_wr && (i_data_addr == memory_map_pkg::ADDR_REMAP_COMMIT);
  wire wr_flash_ctl  = i_data_wr && (i_data_addr == memory_map_pkg::ADDR_FLASH_CTRL);
  wire wr_flash_cmt  = i_data_wr && (i_data_addr == memory_map_pkg::ADDR_FLASH_COMMIT);
  // Commit code matches
  wire cmt_remap     = wr_remap_cmt && (i_data_wdata == memory_map_pkg::CODE_REMAP);
  wire cmt_reset_dis = wr_remap_cmt && (i_data_wdata == memory_map_pkg::CODE_RESET_DIS);
  wire cmt_fault_clr = wr_remap_cmt && (i_data_wdata == memory_map_pkg::CODE_FAULT_CLR);
  wire cmt_flash     = wr_flash_cmt && (i_data_wdata == memory_map_pkg::CODE_FLASH);

  // Pending select register, only the three low bits are stored
  // The upper bits are not kept at all, so they read back as zero for free
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      remap_pending <= memory_map_pkg::REMAP_RESET;
    end else if (wr_remap_sel) begin
      remap_pending <= i_data_wdata[2:0];
    end
  end

  // Committed RAM and vector selects change only on the 0xD4 code
  // Both bits move on the same edge, so the RAM window and the relocated
  // vectors never appear out of step with each other
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      code_ram_active_flag        <= 1'b0;
      vector_relocate_active_flag <= 1'b0;
    end else if (cmt_remap) begin
      code_ram_active_flag        <= remap_pending[memory_map_pkg::BIT_CODE_RAM];
      vector_relocate_active_flag <= remap_pending[memory_map_pkg::BIT_VECTOR];
    end
  end

  // Reset-disable applies on 0xB2; fault clear is a strobe on 0x71
  // The strobe lasts one cycle for each cycle the code is held; the status block it feeds clears
  // its fault flag on that cycle and needs no acknowledge back
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reset_disable     <= 1'b0;
      fault_clear_pulse <= 1'b0;
    end else begin
      if (cmt_reset_dis) begin
        reset_disable <= remap_pending[memory_map_pkg::BIT_RESET_DIS];
      end
      fault_clear_pulse <= cmt_fault_clr;
    end
  end

  // Flash control written copy
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flash_control <= memory_map_pkg::FLASH_RESET;
    end else if (wr_flash_ctl) begin
      flash_control <= i_data_wdata;
    end
  end

  // Active shadow loads only on the 0xD5 code; boot ROM stays off after reset
  // A store to the written copy alone never moves the boot window, so
  // software may prepare the copy while running from the boot ROM
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flash_shadow_monitor <= memory_map_pkg::FLASH_RESET;
    end else if (cmt_flash) begin
      flash_shadow_monitor <= flash_control;
    end
  end

  // Effective mapping controls
  wire boot_rom_select = flash_shadow_monitor[memory_map_pkg::BIT_BOOT_ROM];
  // Serial PROM mode overrides the software select
  wire ram_in_code     = code_ram_active_flag || i_serial_prom_mode;

  // Address window test, shared by both spaces
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Vector relocation of the fetch address
  logic [15:0] code_vec_addr;
  logic        code_vec_hit;
  vector_relocate u_vector_relocate (
    .i_addr     (i_code_addr),
    .i_relocate (vector_relocate_active_flag),
    .o_addr     (code_vec_addr),
    .o_hit      (code_vec_hit)
  );

  // Code space windows
  wire c_ram   = in_range(i_code_addr, memory_map_pkg::RAM_LO, memory_map_pkg::RAM_HI);
  // Boot window is 2 KB; outside PROM mode nothing beyond is visible
  wire c_boot  = in_range(i_code_addr, memory_map_pkg::BOOT_LO, memory_map_pkg::BOOT_HI);
  wire c_flash = in_range(i_code_addr, memory_map_pkg::FLASH_LO, memory_map_pkg::FLASH_HI);

  // Code decode in priority order; remapped windows first
  // Relocated vectors are tested before anything else because their
  // default addresses lie inside the flash window
  // The RAM window comes next; it never overlaps the boot or flash windows
  // Addresses outside every window get no target; the core sees no memory
  logic [2:0] next_code_target;
  always_comb begin
    if (code_vec_hit) begin
      next_code_target = 3'(memory_map_pkg::TGT_RAM);
    end else if (c_ram) begin
      // Unmapped RAM window answers with the trap opcode
      next_code_target = ram_in_code ? 3'(memory_map_pkg::TGT_RAM) : 3'(memory_map_pkg::TGT_SWI);
    end else if (c_boot) begin
      if (boot_rom_select) begin
        next_code_target = 3'(memory_map_pkg::TGT_BOOT);
      end else begin
        // Small flash parts have nothing behind this window
        next_code_target = FLASH_COVERS_BOOT ? 3'(memory_map_pkg::TGT_FLASH) : 3'(memory_map_pkg::TGT_SWI);
      end
    end else if (c_flash) begin
      next_code_target = 3'(memory_map_pkg::TGT_FLASH);
    end else begin
      next_code_target = 3'(memory_map_pkg::TGT_NONE);
    end
  end

  assign o_code_target    = next_code_target;
  assign o_code_phys_addr = code_vec_addr;
  assign o_code_force_swi = (next_code_target == 3'(memory_map_pkg::TGT_SWI));

  // Data space windows
  wire d_sfr  = in_range(i_data_addr, memory_map_pkg::SFR1_LO, memory_map_pkg::SFR1_HI) ||
                in_range(i_data_addr, memory_map_pkg::SFR2_LO, memory_map_pkg::SFR2_HI) ||
                in_range(i_data_addr, memory_map_pkg::SFR3_LO, memory_map_pkg::SFR3_HI);
  wire d_ram   = in_range(i_data_addr, memory_map_pkg::RAM_LO, memory_map_pkg::RAM_HI);
  wire d_boot  = in_range(i_data_addr, memory_map_pkg::BOOT_LO, memory_map_pkg::BOOT_HI);
  wire d_flash = in_range(i_data_addr, memory_map_pkg::FLASH_LO, memory_map_pkg::FLASH_HI);

  // Data decode; reads of an unmapped boot window give all ones
  // Register regions come first so that a register address is never taken
  // for memory; the regions do not overlap RAM, so the order is only a guard
  // Vector relocation has no meaning here: it concerns fetches only
  logic [2:0] next_data_target;
  always_comb begin
    if (d_sfr) begin
      next_data_target = 3'(memory_map_pkg::TGT_SFR);
    end else if (d_ram) begin
      next_data_target = 3'(memory_map_pkg::TGT_RAM);
    end else if (d_boot) begin
      next_data_target = boot_rom_select ? 3'(memory_map_pkg::TGT_BOOT) : 3'(memory_map_pkg::TGT_NONE);
    end else if (d_flash) begin
      next_data_target = 3'(memory_map_pkg::TGT_FLASH);
    end else begin
      next_data_target = 3'(memory_map_pkg::TGT_NONE);
    end
  end

  assign o_data_target   = next_data_target;
  assign o_data_force_ff = i_data_rd && d_boot && !boot_rom_select;

  // Register read mux; commit address reads back status
  wire [7:0] remap_status = {5'h00, vector_relocate_active_flag, code_ram_active_flag, reset_disable};
  wire [7:0] remap_select = {5'h00, remap_pending};
  assign o_reg_hit = (i_data_addr == memory_map_pkg::ADDR_REMAP_SELECT) ||
                     (i_data_addr == memory_map_pkg::ADDR_REMAP_COMMIT) ||
                     (i_data_addr == memory_map_pkg::ADDR_FLASH_CTRL)   ||
                     (i_data_addr == memory_map_pkg::ADDR_FLASH_COMMIT) ||
                     (i_data_addr == memory_map_pkg::ADDR_FLASH_MONITOR);
  // Read data is registered; flash commit is write-only and reads as all ones
  // The mux follows the address every cycle, so read data is valid one cycle
  // after the address whether or not a read strobe was given
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else begin
      unique case (i_data_addr)
        memory_map_pkg::ADDR_REMAP_SELECT:  o_reg_rdata <= remap_select;
        memory_map_pkg::ADDR_REMAP_COMMIT:  o_reg_rdata <= remap_status;
        memory_map_pkg::ADDR_FLASH_CTRL:    o_reg_rdata <= flash_control;
        memory_map_pkg::ADDR_FLASH_MONITOR: o_reg_rdata <= flash_shadow_monitor;
        default:                            o_reg_rdata <= memory_map_pkg::UNMAPPED;
      endcase
    end
  end

  // Committed controls; the gear-clock timing of 0xB2/0x71 is software's duty
  // All three come straight from flip-flops, so the blocks that use them see
  // no glitches from the address decode
  assign o_reset_disable     = reset_disable;
  assign o_fault_clear_pulse = fault_clear_pulse;
  assign o_flash_control     = flash_shadow_monitor;
endmodule // memory_map_remap_control

// ---- tb/memory_map_asserts.sv ----
// Watches decode results and commit side effects at the block's ports
module memory_map_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_resetn,
  // Fetch side
  input wire logic        i_serial_prom_mode,
  input wire logic [15:0] i_code_addr,
  input wire logic [2:0]  o_code_target,
  input wire logic [15:0] o_code_phys_addr,
  input wire logic        o_code_force_swi,
  // Data side
  input wire logic [15:0] i_data_addr,
  input wire logic        i_data_rd,
  input wire logic        i_data_wr,
  input wire logic [7:0]  i_data_wdata,
  input wire logic [2:0]  o_data_target,
  input wire logic        o_data_force_ff,
  input wire logic        o_reg_hit,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_reset_disable,
  input wire logic        o_fault_clear_pulse,
  input wire logic [7:0]  o_flash_control
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Store to the remap commit register
  wire commit_wr = i_data_wr && i_data_addr == 16'h0fdf;
  // Fetch inside the RAM window
  wire ram_code  = i_code_addr inside {[16'h0040:16'h083f]};

  data_ram_a: assert property (i_data_addr inside {[16'h0040:16'h083f]} |-> o_data_target == 3'h1)
    else $error("data RAM window not decoded");
  prom_ram_a: assert property (i_serial_prom_mode && ram_code |-> o_code_target == 3'h1 && !o_code_force_swi)
    else $error("serial PROM mode lost code RAM");
  ram_swi_a: assert property (ram_code && o_code_target != 3'h1 |-> o_code_force_swi)
    else $error("unmapped code RAM fetch not forced to SOFTWARE_INTERRUPT_OPCODE");
  code_flash_a: assert property (i_code_addr inside {[16'hc000:16'hff9f]} |-> o_code_target == 3'h3)
    else $error("code flash window not decoded");
  reset_vector_a: assert property (i_code_addr >= 16'hfffe |-> o_code_phys_addr == i_code_addr && o_code_target == 3'h3)
    else $error("reset vector moved");
  sfr_data_a: assert property (i_data_addr inside {[16'h0000:16'h003f], [16'h0e40:16'h0fff]} |-> o_data_target == 3'h4)
    else $error("register region not decoded");
  boot_ff_a: assert property (i_data_rd && i_data_addr inside {[16'h1000:16'h17ff]} && o_data_target != 3'h2 |-> o_data_force_ff)
    else $error("unmapped boot data read not 0xff");
  upper_zero_a: assert property (i_data_rd && i_data_addr inside {16'h0fde, 16'h0fdf} |=> o_reg_rdata[7:3] == 5'h0)
    else $error("upper select bits not zero");
  flash_hold_a: assert property (i_data_wr && i_data_addr == 16'h0fd1 && i_data_wdata != 8'hd5 |=> $stable(o_flash_control))
    else $error("flash shadow moved without its code");
  fault_pulse_a: assert property (commit_wr && i_data_wdata == 8'h71 |=> o_fault_clear_pulse ##1 !o_fault_clear_pulse)
    else $error("fault clear pulse wrong");
  disable_cause_a: assert property ($changed(o_reset_disable) |-> $past(commit_wr && i_data_wdata == 8'hb2))
    else $error("reset disable changed without its code");
  reg_hit_a: assert property (o_reg_hit == (i_data_addr inside {16'h0fd0, 16'h0fd1, 16'h0fd2, 16'h0fde, 16'h0fdf}))
    else $error("register hit decode wrong");
endmodule // memory_map_asserts

bind memory_map_remap_control memory_map_asserts i_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_serial_prom_mode(i_serial_prom_mode),
  .i_code_addr(i_code_addr), .o_code_target(o_code_target), .o_code_phys_addr(o_code_phys_addr),
  .o_code_force_swi(o_code_force_swi), .i_data_addr(i_data_addr), .i_data_rd(i_data_rd),
  .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata), .o_data_target(o_data_target),
  .o_data_force_ff(o_data_force_ff), .o_reg_hit(o_reg_hit), .o_reg_rdata(o_reg_rdata),
  .o_reset_disable(o_reset_disable),
  .o_fault_clear_pulse(o_fault_clear_pulse), .o_flash_control(o_flash_control));

// ---- tb/cpu_core_model.sv ----
// Stands in for the CPU core's fetch and data buses
module cpu_core_model (
  // Clock
  input  wire logic        i_clk,
  // Buses toward the block
  output logic      [15:0] o_code_addr,
  output logic      [15:0] o_data_addr,
  output logic             o_data_rd,
  output logic             o_data_wr,
  output logic      [7:0]  o_data_wdata,
  // Marks a request whose answer is to be checked
  output logic             o_look
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial begin
    o_code_addr = 16'hc000;
    o_data_addr = 16'h0fdf;
    o_data_rd = 1'b0;
    o_data_wr = 1'b0;
    o_data_wdata = 8'h00;
    o_look = 1'b0;
  end
  // Plain byte store only, never a read-modify-write of a commit register
  // Reset-disable and fault-clear codes go out with the gear at its reset setting
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_data_addr = a;
    o_data_wdata = d;
    o_data_wr = 1'b1;
    @(negedge i_clk);
    o_data_wr = 1'b0;
    o_data_wdata = ~d; // Released data must not keep showing the byte
  endtask
  // Read or fetch held one cycle; read data is due one cycle after the address
  task automatic req(input logic [15:0] a, input logic is_read);
    @(negedge i_clk);
    if (is_read) begin
      o_data_addr = a;
      o_data_rd = 1'b1;
    end else begin
      o_code_addr = a;
    end
    o_look = 1'b1;
    @(negedge i_clk);
    o_data_rd = 1'b0;
    o_look = 1'b0;
  endtask
endmodule // cpu_core_model

// ---- tb/memory_map_remap_control_bench.sv ----
// Self-checking bench for the remap controller
module memory_map_remap_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] k; logic [19:0] v;} note_type;
  note_type    q[$];            // Expected results, oldest first
  string       nm[4] = '{"register read", "fetch decode", "data decode", "control outputs"};
  logic        i_clk, i_resetn, prom, look, rd, wr, software_interrupt_opcode, ff, rdis;
  logic [15:0] caddr, daddr, phys;
  logic [7:0]  wdata, rdata, fctl;
  logic [2:0]  ctgt, dtgt;
  logic [31:0] seed;
  int          failures, checks, cycles;
  // Vector fetch table and its expected {swi, target, address}
  logic [15:0] va[6] = '{16'hffa0, 16'hffbf, 16'hffcc, 16'hfffd, 16'hfffe, 16'h0040};
  logic [19:0] ve[6] = '{20'h101a0, 20'h101bf, 20'h101cc, 20'h101fd, 20'h3fffe, 20'h10040};

  cpu_core_model i_cpu (.i_clk(i_clk), .o_code_addr(caddr), .o_data_addr(daddr), .o_data_rd(rd),
    .o_data_wr(wr), .o_data_wdata(wdata), .o_look(look));
  memory_map_remap_control i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_serial_prom_mode(prom),
    .i_code_addr(caddr), .o_code_target(ctgt), .o_code_phys_addr(phys), .o_code_force_swi(software_interrupt_opcode),
    .i_data_addr(daddr), .i_data_rd(rd), .i_data_wr(wr), .i_data_wdata(wdata), .o_data_target(dtgt),
    .o_data_force_ff(ff), .o_reg_hit(), .o_reg_rdata(rdata), .o_reset_disable(rdis),
    .o_fault_clear_pulse(), .o_flash_control(fctl));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {force_ff, target} of a data read; b is the committed boot select
  function automatic logic [19:0] dref(input logic [15:0] a, input logic b);
    if (a <= 16'h003f || a inside {[16'h0e40:16'h0fff]}) return 20'h4;
    if (a inside {[16'h0040:16'h083f]}) return 20'h1;
    if (a inside {[16'h1000:16'h17ff]}) return b ? 20'h2 : 20'h8;
    return a >= 16'hc000 ? 20'h3 : 20'h0;
  endfunction
  // Note the expectation, then make the request that answers it
  task automatic probe(input logic [1:0] k, input logic [15:0] a, input logic [19:0] v);
    q.push_back('{k, v});
    i_cpu.req(a, k != 2'h1);
  endtask
  // Random data reads against the reference decode
  task automatic rand_reads(input logic b);
    repeat (150) begin
      seed = lfsr(seed);
      probe(2'h2, seed[15:0], dref(seed[15:0], b));
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Takes the oldest note when an answer is due; waits for the edge's updates
  always @(posedge i_clk) begin
    logic [19:0] seen;
    note_type    n;
    #1;
    if (look) begin
      n = q.pop_front();
      case (n.k)
        2'h0: seen = {12'h0, rdata};
        2'h1: seen = {software_interrupt_opcode, ctgt, phys};
        2'h2: seen = {16'h0, ff, dtgt};
        default: seen = {3'h0, rdis, fctl, rdata};
      endcase
      checks++;
      if (seen !== n.v) begin
        failures++;
        $display("wrong value %s expected %h seen %h", nm[n.k], n.v, seen);
      end
    end
  end
  // Hang guard, far above the roughly 700 cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    i_resetn = 1'b0;
    prom = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    seed = 32'ha97ed7fc;
    repeat (12) @(negedge i_clk);
    i_resetn = 1'b1;
    probe(2'h0, 16'h0fde, 20'h0);
    probe(2'h0, 16'h0fdf, 20'h0);
    probe(2'h3, 16'h0fd2, 20'h04040);
    probe(2'h1, 16'h0040, 20'hd0040);
    probe(2'h1, 16'h1000, 20'hd1000);
    probe(2'h1, 16'hc000, 20'h3c000);
    probe(2'h1, 16'hffa0, 20'h3ffa0);
    rand_reads(1'b0);
    // Pending selects wait for the remap code; other codes do nothing
    i_cpu.wr(16'h0fde, 8'hfe);
    probe(2'h0, 16'h0fde, 20'h6);
    probe(2'h0, 16'h0fdf, 20'h0);
    i_cpu.wr(16'h0fdf, 8'hd5);
    probe(2'h0, 16'h0fdf, 20'h0);
    i_cpu.wr(16'h0fdf, 8'hd4);
    probe(2'h0, 16'h0fdf, 20'h6);
    for (int i = 0; i < 6; i++) probe(2'h1, va[i], ve[i]);
    i_cpu.wr(16'h0fde, 8'h00);
    probe(2'h0, 16'h0fdf, 20'h6);
    i_cpu.wr(16'h0fdf, 8'hd4);
    probe(2'h1, 16'h0040, 20'hd0040);
    i_cpu.wr(16'h0fde, 8'h01);
    i_cpu.wr(16'h0fdf, 8'hb2);
    probe(2'h3, 16'h0fd2, 20'h14040);
    i_cpu.wr(16'h0fdf, 8'h71);
    @(negedge i_clk) prom = 1'b1;
    probe(2'h1, 16'h0040, 20'h10040);
    i_cpu.wr(16'h0fde, 8'h04);
    i_cpu.wr(16'h0fdf, 8'hd4);
    probe(2'h1, 16'hffcc, 20'h101cc);
    @(negedge i_clk) prom = 1'b0;
    // Flash control is double-buffered
    i_cpu.wr(16'h0fd0, 8'h50);
    probe(2'h0, 16'h0fd0, 20'h50);
    i_cpu.wr(16'h0fd1, 8'h00);
    probe(2'h3, 16'h0fd2, 20'h14040);
    i_cpu.wr(16'h0fd1, 8'hd5);
    probe(2'h3, 16'h0fd2, 20'h15050);
    probe(2'h1, 16'h1000, 20'h21000);
    probe(2'h1, 16'h17ff, 20'h217ff);
    rand_reads(1'b1);
    // A second reset brings back the defaults
    @(negedge i_clk) i_resetn = 1'b0;
    @(negedge i_clk) i_resetn = 1'b1;
    probe(2'h3, 16'h0fd2, 20'h04040);
    probe(2'h1, 16'h1000, 20'hd1000);
    end_of_test();
  end
endmodule // memory_map_remap_control_bench
